// ===== hw/frs_seq.v
// Field reversal sequencer for a two-quadrant drive, Wishbone slave
//
// Functional notes
// - Direction input 0 closes positive contactor, 1 closes negative one.
// - A level change of the direction input starts a full reversal.
// - A running reversal completes; later direction changes act only once it ends.
// - Direction reversal starts only when the brake input is low, triggered or not.
// - Wait for zero armature current, inhibit armature, hold wait state.
// - Inhibit field, await field below minimum; zero setpoint inhibits.
// - Wait first time, then open the closed field contactor.
// - Wait second time, then close the contactor for the new direction.
// - Invert speed actual value after closing the negative contactor, except with EMF feedback.
// - Wait third time, then re-enable field firing pulses.
// - Await field above setpoint times factor, fourth time, then release.
// - Brake triggers after 30 ms high input with line contactor closed.
// - Brake reverses field only if internal speed is negative.
// - After brake reversal: zero speed setpoint, wait for low speed.
// - Zero current, inhibit armature, switch-on inhibit while brake high.
// - Brake released: reverse back if needed, fifth wait, armature on.
// - Contactor output high drives its contactor; low leaves it undriven.
`timescale 1ns/10ps
`include "frs_defines.vh"
module frs_seq #(
   parameter TICK_CYCLES  = `FRS_CLK_FREQ_HZ / 1000 * `FRS_TICK_MS,
   parameter BRAKE_CYCLES = `FRS_CLK_FREQ_HZ / 1000 * `FRS_BRAKE_MIN_MS
) (
   input  wire        mclk_in,
   input  wire        srst_in,
   input  wire        wb_cyc_in,
   input  wire        wb_stb_in,
   input  wire        wb_we_in,
   input  wire [5:0]  wb_adr_in,
   input  wire [3:0]  wb_sel_in,
   input  wire [31:0] wb_dat_in,
   output reg  [31:0] wb_dat_out,
   output reg         wb_ack_out,
   input  wire        direction_select_in,
   input  wire        field_brake_in,
   input  wire        line_contactor_closed_in,
   input  wire        armature_current_zero_in,
   input  wire [15:0] field_current_actual_in,
   input  wire [15:0] field_current_setpoint_in,
   input  wire [15:0] speed_actual_in,
   input  wire        restart_ack_in,
   output reg         field_contactor_pos_out,
   output reg         field_contactor_neg_out,
   output reg         armature_pulse_inhibit_out,
   output reg         field_pulse_inhibit_out,
   output reg         speed_invert_out,
   output reg  [15:0] speed_internal_out,
   output reg         zero_speed_setpoint_out,
   output reg         pulse_inhibit_wait_state_out,
   output reg         switch_on_inhibit_state_out
);

   localparam [11:0] ST_IDLE      = 12'h001;
   localparam [11:0] ST_ARM_WAIT  = 12'h002;
   localparam [11:0] ST_FLD_OFF   = 12'h004;
   localparam [11:0] ST_WAIT0     = 12'h008;
   localparam [11:0] ST_WAIT1     = 12'h010;
   localparam [11:0] ST_WAIT2     = 12'h020;
   localparam [11:0] ST_FLD_ON    = 12'h040;
   localparam [11:0] ST_WAIT_LAST = 12'h080;
   localparam [11:0] ST_BRK_RAMP  = 12'h100;
   localparam [11:0] ST_BRK_ARM   = 12'h200;
   localparam [11:0] ST_BRK_HOLD  = 12'h400;
   localparam [11:0] ST_INHIBIT   = 12'h800;

   function [15:0] frs_merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  sel;
      begin
         frs_merge16[7:0]  = sel[0] ? data[7:0]  : old[7:0];
         frs_merge16[15:8] = sel[1] ? data[15:8] : old[15:8];
      end
   endfunction

   function [15:0] frs_abs16;
      input [15:0] value;
      begin
         frs_abs16 = value[15] ? (16'h0000 - value) : value;
      end
   endfunction

   // Register file
   reg  [3:0]  speed_feedback_select;
   reg  [15:0] field_current_min;
   reg  [15:0] field_current_on_factor;
   reg  [15:0] speed_min_threshold;
   reg  [13:0] reversal_wait_times [0:4];

   // Sequencer state
   reg  [11:0] state;
   reg  [1:0]  seq_kind;
   reg         field_neg;
   reg         target_neg;
   reg         brake_armed;
   reg  [23:0] brake_count;
   reg         timer_load;
   reg  [13:0] timer_value;
   reg         field_inhibit;
   reg  [15:0] speed_mag;
   reg  [13:0] wr_wait;
   wire        timer_done;
   wire [1:0]  pins_sync;
   wire        dir_sync;
   wire        brake_sync;
   wire [31:0] field_on_level;
   wire        bus_req;
   wire [2:0]  wait_idx;

   assign dir_sync       = pins_sync[0];
   assign brake_sync     = pins_sync[1];
   assign bus_req        = wb_cyc_in & wb_stb_in;
   // Slots start at the first wait offset; the 3-bit wrap puts the last at 4
   assign wait_idx       = wb_adr_in[4:2] - 3'h4;
   assign field_on_level = field_current_setpoint_in * field_current_on_factor;

   frs_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .mclk_in  (mclk_in),
      .srst_in  (srst_in),
      .async_in ({field_brake_in, direction_select_in}),
      .sync_out (pins_sync)
   );

   frs_wait_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_wait_timer (
      .mclk_in     (mclk_in),
      .srst_in     (srst_in),
      .load_in     (timer_load),
      .value_ms_in (timer_value),
      .done_out    (timer_done)
   );

   always @* begin
      // Whole word compared so high bits cannot slip past the limit
      wr_wait = (wb_dat_in > {18'h00000, `FRS_WAIT_MAX_MS}) ?
                `FRS_WAIT_MAX_MS : wb_dat_in[13:0];
      speed_mag = frs_abs16(speed_internal_out);
   end

   // Bus slave: ack one cycle after the request, write at the ack edge
   always @(posedge mclk_in) begin
      if (srst_in) begin
         wb_ack_out              <= 1'b0;
         wb_dat_out              <= 32'h00000000;
         speed_feedback_select   <= `FRS_RST_SFS;
         field_current_min       <= `FRS_RST_FLD_MIN;
         field_current_on_factor <= `FRS_RST_FLD_FACTOR;
         speed_min_threshold     <= `FRS_RST_SPEED_MIN;
         reversal_wait_times[0]  <= `FRS_RST_WAIT0_MS;
         reversal_wait_times[1]  <= `FRS_RST_WAIT1_MS;
         reversal_wait_times[2]  <= `FRS_RST_WAIT2_MS;
         reversal_wait_times[3]  <= `FRS_RST_WAIT3_MS;
         reversal_wait_times[4]  <= `FRS_RST_WAIT4_MS;
      end else begin
         wb_ack_out <= bus_req & ~wb_ack_out;
         if (bus_req && !wb_ack_out) begin
            wb_dat_out <= 32'h00000000;
            if (wb_adr_in == `FRS_ADR_CONFIG) begin
               wb_dat_out[`FRS_SFS_MSB:`FRS_SFS_LSB] <= speed_feedback_select;
            end else if (wb_adr_in == `FRS_ADR_FLD_MIN) begin
               wb_dat_out[15:0] <= field_current_min;
            end else if (wb_adr_in == `FRS_ADR_FLD_FACTOR) begin
               wb_dat_out[15:0] <= field_current_on_factor;
            end else if (wb_adr_in == `FRS_ADR_SPEED_MIN) begin
               wb_dat_out[15:0] <= speed_min_threshold;
            end else if (wb_adr_in >= `FRS_ADR_WAIT0 &&
                         wb_adr_in <= `FRS_ADR_WAIT4) begin
               wb_dat_out[13:0] <= reversal_wait_times[wait_idx];
            end else if (wb_adr_in == `FRS_ADR_STATUS) begin
               wb_dat_out[11:0]  <= state;
               wb_dat_out[12]    <= field_contactor_pos_out;
               wb_dat_out[13]    <= field_contactor_neg_out;
               wb_dat_out[14]    <= field_neg;
               wb_dat_out[15]    <= brake_armed;
               wb_dat_out[17:16] <= seq_kind;
               wb_dat_out[18]    <= speed_invert_out;
               wb_dat_out[19]    <= pulse_inhibit_wait_state_out;
               wb_dat_out[20]    <= switch_on_inhibit_state_out;
            end
         end
         if (bus_req && wb_ack_out && wb_we_in) begin
            if (wb_adr_in == `FRS_ADR_CONFIG) begin
               if (wb_sel_in[0]) begin
                  speed_feedback_select <=
                     wb_dat_in[`FRS_SFS_MSB:`FRS_SFS_LSB];
               end
            end else if (wb_adr_in == `FRS_ADR_FLD_MIN) begin
               field_current_min <=
                  frs_merge16(field_current_min, wb_dat_in, wb_sel_in);
            end else if (wb_adr_in == `FRS_ADR_FLD_FACTOR) begin
               field_current_on_factor <=
                  frs_merge16(field_current_on_factor, wb_dat_in, wb_sel_in);
            end else if (wb_adr_in == `FRS_ADR_SPEED_MIN) begin
               speed_min_threshold <=
                  frs_merge16(speed_min_threshold, wb_dat_in, wb_sel_in);
            end else if (wb_adr_in >= `FRS_ADR_WAIT0 &&
                         wb_adr_in <= `FRS_ADR_WAIT4) begin
               // Both low byte lanes required: a half-written time would be garbage
               if (wb_sel_in[1:0] == 2'b11) begin
                  reversal_wait_times[wait_idx] <= wr_wait;
               end
            end
         end
      end
   end

   // Brake input qualification
   always @(posedge mclk_in) begin
      if (srst_in) begin
         brake_count <= 24'h000000;
         brake_armed <= 1'b0;
      end else if (!brake_sync || !line_contactor_closed_in) begin
         brake_count <= 24'h000000;
         brake_armed <= 1'b0;
      end else if (brake_count < BRAKE_CYCLES[23:0]) begin
         brake_count <= brake_count + 24'h000001;
      end else begin
         brake_armed <= 1'b1;
      end
   end

   // Sequencer
   always @(posedge mclk_in) begin
      if (srst_in) begin
         state                        <= ST_IDLE;
         seq_kind                     <= `FRS_KIND_DIR;
         field_neg                    <= 1'b0;
         target_neg                   <= 1'b0;
         timer_load                   <= 1'b0;
         timer_value                  <= 14'h0000;
         field_inhibit                <= 1'b0;
         field_contactor_pos_out      <= 1'b1;
         field_contactor_neg_out      <= 1'b0;
         armature_pulse_inhibit_out   <= 1'b0;
         field_pulse_inhibit_out      <= 1'b0;
         speed_invert_out             <= 1'b0;
         speed_internal_out           <= 16'h0000;
         zero_speed_setpoint_out      <= 1'b0;
         pulse_inhibit_wait_state_out <= 1'b0;
         switch_on_inhibit_state_out  <= 1'b0;
      end else begin
         timer_load <= 1'b0;
         speed_internal_out <= speed_invert_out ?
                               (16'h0000 - speed_actual_in) : speed_actual_in;
         field_pulse_inhibit_out <= field_inhibit |
                                    (field_current_setpoint_in == 16'h0000);
         case (state)
            ST_IDLE: begin
               if (brake_armed && speed_internal_out[15]) begin
                  seq_kind                     <= `FRS_KIND_BRAKE;
                  target_neg                   <= ~field_neg;
                  pulse_inhibit_wait_state_out <= 1'b1;
                  state                        <= ST_ARM_WAIT;
               end else if (dir_sync != field_neg && !brake_sync) begin
                  seq_kind                     <= `FRS_KIND_DIR;
                  target_neg                   <= dir_sync;
                  pulse_inhibit_wait_state_out <= 1'b1;
                  state                        <= ST_ARM_WAIT;
               end
            end
            ST_ARM_WAIT: begin
               if (armature_current_zero_in) begin
                  armature_pulse_inhibit_out <= 1'b1;
                  field_inhibit              <= 1'b1;
                  state                      <= ST_FLD_OFF;
               end
            end
            ST_FLD_OFF: begin
               if (field_current_actual_in < field_current_min) begin
                  timer_load  <= 1'b1;
                  timer_value <= reversal_wait_times[0];
                  state       <= ST_WAIT0;
               end
            end
            ST_WAIT0: begin
               if (timer_done && !timer_load) begin
                  field_contactor_pos_out <= 1'b0;
                  field_contactor_neg_out <= 1'b0;
                  timer_load              <= 1'b1;
                  timer_value             <= reversal_wait_times[1];
                  state                   <= ST_WAIT1;
               end
            end
            ST_WAIT1: begin
               if (timer_done && !timer_load) begin
                  field_contactor_pos_out <= ~target_neg;
                  field_contactor_neg_out <= target_neg;
                  field_neg               <= target_neg;
                  speed_invert_out <= target_neg &
                     (speed_feedback_select != `FRS_SFS_EMF);
                  timer_load  <= 1'b1;
                  timer_value <= reversal_wait_times[2];
                  state       <= ST_WAIT2;
               end
            end
            ST_WAIT2: begin
               if (timer_done && !timer_load) begin
                  field_inhibit <= 1'b0;
                  state         <= ST_FLD_ON;
               end
            end
            ST_FLD_ON: begin
               if ({8'h00, field_current_actual_in, 8'h00} >
                   field_on_level) begin
                  timer_load  <= 1'b1;
                  timer_value <= (seq_kind == `FRS_KIND_RETURN) ?
                                 reversal_wait_times[4] :
                                 reversal_wait_times[3];
                  state       <= ST_WAIT_LAST;
               end
            end
            ST_WAIT_LAST: begin
               // the timed reversal ends here; a brake sequence returns to ST_IDLE only from ST_INHIBIT
               if (timer_done && !timer_load) begin
                  armature_pulse_inhibit_out   <= 1'b0;
                  pulse_inhibit_wait_state_out <= 1'b0;
                  if (seq_kind == `FRS_KIND_BRAKE) begin
                     zero_speed_setpoint_out <= 1'b1;
                     state                   <= ST_BRK_RAMP;
                  end else if (seq_kind == `FRS_KIND_RETURN) begin
                     state <= ST_INHIBIT;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_BRK_RAMP: begin
               if (speed_mag < speed_min_threshold) begin
                  state <= ST_BRK_ARM;
               end
            end
            ST_BRK_ARM: begin
               if (armature_current_zero_in) begin
                  armature_pulse_inhibit_out  <= 1'b1;
                  switch_on_inhibit_state_out <= 1'b1;
                  state                       <= ST_BRK_HOLD;
               end
            end
            ST_BRK_HOLD: begin
               if (!brake_sync) begin
                  if (dir_sync != field_neg) begin
                     seq_kind                     <= `FRS_KIND_RETURN;
                     target_neg                   <= dir_sync;
                     pulse_inhibit_wait_state_out <= 1'b1;
                     state                        <= ST_ARM_WAIT;
                  end else begin
                     armature_pulse_inhibit_out <= 1'b0;
                     state                      <= ST_INHIBIT;
                  end
               end
            end
            ST_INHIBIT: begin
               if (restart_ack_in) begin
                  switch_on_inhibit_state_out <= 1'b0;
                  zero_speed_setpoint_out     <= 1'b0;
                  state                       <= ST_IDLE;
               end
            end
            default: begin
               field_contactor_pos_out <= 1'b0;
               field_contactor_neg_out <= 1'b0;
               state                   <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // frs_seq

// ===== hw/frs_defines.vh
// Constants of the field reversal sequencer: map, resets and timing
`ifndef FRS_DEFINES_VH
`define FRS_DEFINES_VH

`define FRS_CLK_FREQ_HZ      125000000
`define FRS_TICK_MS          1
`define FRS_BRAKE_MIN_MS     30

`define FRS_ADR_CONFIG       6'h00
`define FRS_ADR_FLD_MIN      6'h04
`define FRS_ADR_FLD_FACTOR   6'h08
`define FRS_ADR_SPEED_MIN    6'h0c
`define FRS_ADR_WAIT0        6'h10
`define FRS_ADR_WAIT4        6'h20
`define FRS_ADR_STATUS       6'h24

`define FRS_SFS_LSB          0
`define FRS_SFS_MSB          3
`define FRS_SFS_EMF          4'h3

`define FRS_RST_SFS          4'h0
`define FRS_RST_FLD_MIN      16'h0100
`define FRS_RST_FLD_FACTOR   16'h00cc
`define FRS_RST_SPEED_MIN    16'h0040

`define FRS_WAIT_MAX_MS      14'h2710
`define FRS_RST_WAIT0_MS     14'h0bb8
`define FRS_RST_WAIT1_MS     14'h00c8
`define FRS_RST_WAIT2_MS     14'h0064
`define FRS_RST_WAIT3_MS     14'h0bb8
`define FRS_RST_WAIT4_MS     14'h0bb8

`define FRS_FACTOR_FRAC      8

`define FRS_KIND_DIR         2'h0
`define FRS_KIND_BRAKE       2'h1
`define FRS_KIND_RETURN      2'h2

`endif

// ===== hw/frs_sync.v
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module frs_sync #(
   parameter WIDTH = 2
) (
   input  wire             mclk_in,
   input  wire             srst_in,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   always @(posedge mclk_in) begin
      if (srst_in) begin
         stage1   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // frs_sync

// ===== hw/frs_wait_timer.v
// Millisecond down-counter for the timed reversal steps
`timescale 1ns/10ps
module frs_wait_timer #(
   parameter TICK_CYCLES = 125000
) (
   input  wire        mclk_in,
   input  wire        srst_in,
   input  wire        load_in,
   input  wire [13:0] value_ms_in,
   output reg         done_out
);

   reg [16:0] prescale;
   reg [13:0] remain;

   // Prescaler restarts on load so every ms counted is a whole one
   always @(posedge mclk_in) begin
      if (srst_in) begin
         prescale <= 17'h00000;
         remain   <= 14'h0000;
         done_out <= 1'b1;
      end else if (load_in) begin
         prescale <= 17'h00000;
         remain   <= value_ms_in;
         done_out <= (value_ms_in == 14'h0000);
      end else if (!done_out) begin
         if (prescale == TICK_CYCLES[16:0] - 17'h00001) begin
            prescale <= 17'h00000;
            remain   <= remain - 14'h0001;
            done_out <= (remain == 14'h0001);
         end else begin
            prescale <= prescale + 17'h00001;
         end
      end
   end

endmodule // frs_wait_timer

// ===== bench/frs_checker.sv
// Port-level assertions on the field reversal sequencer
`timescale 1ns/10ps
module frs_checker (
   input wire logic        mclk_in,
   input wire logic        srst_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_ack_out,
   input wire logic        armature_current_zero_in,
   input wire logic [15:0] field_current_setpoint_in,
   input wire logic [15:0] speed_actual_in,
   input wire logic        restart_ack_in,
   input wire logic        field_contactor_pos_out,
   input wire logic        field_contactor_neg_out,
   input wire logic        armature_pulse_inhibit_out,
   input wire logic        field_pulse_inhibit_out,
   input wire logic        speed_invert_out,
   input wire logic [15:0] speed_internal_out,
   input wire logic        pulse_inhibit_wait_state_out,
   input wire logic        switch_on_inhibit_state_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   excl_contact_a: assert property (
      !(field_contactor_pos_out && field_contactor_neg_out))
      else $error("both field contactors driven");
   idle_dir_a: assert property (
      !pulse_inhibit_wait_state_out && !switch_on_inhibit_state_out
      |-> field_contactor_pos_out ^ field_contactor_neg_out)
      else $error("no single contactor outside a sequence");
   ack_latency_a: assert property (
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("bus answer late");
   swap_inhib_a: assert property (
      $changed({field_contactor_pos_out, field_contactor_neg_out})
      |-> armature_pulse_inhibit_out && field_pulse_inhibit_out)
      else $error("contactor switched with firing enabled");
   arm_zero_a: assert property (
      $rose(armature_pulse_inhibit_out) |-> $past(armature_current_zero_in))
      else $error("armature inhibited with current flowing");
   fld_zero_a: assert property (
      field_current_setpoint_in == 16'h0 |=> field_pulse_inhibit_out)
      else $error("zero setpoint left field firing on");
   speed_inv_a: assert property (
      !$past(srst_in) && $stable(speed_invert_out) |-> speed_internal_out ==
      (speed_invert_out ? 16'h0 - $past(speed_actual_in)
      : $past(speed_actual_in))) else $error("internal speed wrong");
   leave_ack_a: assert property (
      $fell(switch_on_inhibit_state_out)
      |-> $past(restart_ack_in) || $past(restart_ack_in, 2))
      else $error("switch-on inhibit left without acknowledge");
   cover property ($rose(field_contactor_neg_out));
   cover property ($rose(switch_on_inhibit_state_out));
   cover property ($fell(pulse_inhibit_wait_state_out));
endmodule // frs_checker
bind frs_seq frs_checker frs_checker_inst (.*);

// ===== bench/frs_plant.sv
// Behavioural armature and field circuit around the sequencer
`timescale 1ns/10ps
module frs_plant (
   input  wire logic        mclk_in,
   input  wire logic        drive_in,
   input  wire logic        arm_inh_in,
   input  wire logic        fld_inh_in,
   input  wire logic        pos_in,
   input  wire logic        neg_in,
   output wire logic        ia_zero_out,
   output logic      [15:0] fld_out
);
   logic [2:0] ia = 3'h7;
   initial fld_out = 16'h0000;
   assign ia_zero_out = (ia == 3'h0);
   // Current decays over cycles so the zero wait really waits
   always @(posedge mclk_in) begin
      if (drive_in && !arm_inh_in)
         ia <= 3'h7;
      else if (ia != 3'h0)
         ia <= ia - 3'h1;
   end
   // field builds only through one driven contactor
   always @(posedge mclk_in) begin
      if (fld_inh_in || !(pos_in ^ neg_in))
         fld_out <= (fld_out > 16'h0040) ? fld_out - 16'h0040 : 16'h0;
      else
         fld_out <= (fld_out < 16'h0200) ? fld_out + 16'h0040 : 16'h0200;
   end
endmodule // frs_plant

// ===== bench/tb_top.sv
// Self-checking bench for the field reversal sequencer
`timescale 1ns/10ps
module tb_top;
   logic mclk_in = 0, srst_in = 1, wb_cyc_in = 0, wb_stb_in = 0;
   logic wb_we_in = 0, direction_select_in = 0, field_brake_in = 0;
   logic line_contactor_closed_in = 0, restart_ack_in = 0, drive = 1;
   logic [5:0]  wb_adr_in = 6'h00;
   logic [3:0]  wb_sel_in = 4'hf;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
   logic [15:0] field_current_setpoint_in = 16'h0200;
   logic [15:0] speed_actual_in = 16'h0, field_current_actual_in;
   logic [15:0] speed_internal_out;
   logic wb_ack_out, armature_current_zero_in, field_contactor_pos_out;
   logic field_contactor_neg_out, armature_pulse_inhibit_out;
   logic field_pulse_inhibit_out, speed_invert_out, zero_speed_setpoint_out;
   logic pulse_inhibit_wait_state_out, switch_on_inhibit_state_out;
   logic [6:0] mon;
   int errors = 0, n_compared = 0, cnt;
   localparam logic [15:0] RV [9] = '{16'h0, 16'h0100, 16'h00cc, 16'h0040,
      16'h0bb8, 16'h00c8, 16'h0064, 16'h0bb8, 16'h0bb8};
   assign mon = {armature_pulse_inhibit_out, speed_invert_out,
      zero_speed_setpoint_out, switch_on_inhibit_state_out,
      pulse_inhibit_wait_state_out, field_contactor_neg_out,
      field_contactor_pos_out};
   always #4 mclk_in = ~mclk_in;
   frs_seq #(.TICK_CYCLES(10), .BRAKE_CYCLES(40)) frs_seq_inst (.*);
   frs_plant frs_plant_inst (.mclk_in(mclk_in), .drive_in(drive),
      .arm_inh_in(armature_pulse_inhibit_out),
      .fld_inh_in(field_pulse_inhibit_out), .pos_in(field_contactor_pos_out),
      .neg_in(field_contactor_neg_out), .ia_zero_out(armature_current_zero_in),
      .fld_out(field_current_actual_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [5:0] a,
                     input logic [31:0] d);
      @(posedge mclk_in);
      wb_cyc_in <= 1;
      wb_stb_in <= 1;
      wb_we_in <= we;
      wb_adr_in <= a;
      wb_dat_in <= d;
      // No assumed latency: only the watchdog ends a hung request
      do @(posedge mclk_in);
      while (wb_ack_out !== 1'b1);
      q = wb_dat_out;
      wb_cyc_in <= 0;
      wb_stb_in <= 0;
   endtask
   task automatic waitfor(input int b, input logic v);
      cnt = 0;
      while (mon[b] !== v && cnt < 4000) begin
         @(posedge mclk_in);
         cnt++;
      end
      if (cnt >= 4000) errors++;
   endtask
   task automatic reverse(input logic d);
      direction_select_in <= d;
      drive <= 0;
      waitfor(2, 1);
      waitfor(2, 0);
      drive <= 1;
      @(posedge mclk_in);
   endtask
   task automatic tally_and_finish;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk_in);
      srst_in <= 0;
      @(posedge mclk_in);
      check(mon[1:0], 2'b01);
      for (int i = 0; i < 9; i++) begin
         wb(0, 6'(i * 4), 32'h0);
         check(q, {16'h0, RV[i]});
      end
      wb(0, 6'h3c, 32'h0);
      check(q, 32'h0);
      wb(1, 6'h10, 32'h4e20);
      wb(0, 6'h10, 32'h0);
      check(q, 32'h2710);
      wb(1, 6'h10, 32'h3);
      wb(1, 6'h14, 32'h2);
      wb(1, 6'h18, 32'h1);
      wb(1, 6'h1c, 32'h2);
      wb(1, 6'h20, 32'h5);
      field_current_setpoint_in <= 16'h0;
      repeat (3) @(posedge mclk_in);
      check(field_pulse_inhibit_out, 1);
      field_current_setpoint_in <= 16'h0200;
      repeat (20) @(posedge mclk_in);
      direction_select_in <= 1;
      drive <= 0;
      waitfor(2, 1);
      direction_select_in <= 0;
      waitfor(0, 0);
      direction_select_in <= 1;
      waitfor(1, 1);
      check(cnt >= 20 && cnt <= 24, 1);
      check(speed_invert_out, 1);
      waitfor(2, 0);
      check(mon[1:0], 2'b10);
      check(armature_pulse_inhibit_out, 0);
      drive <= 1;
      speed_actual_in <= 16'h0100;
      field_brake_in <= 1;
      direction_select_in <= 0;
      repeat (100) @(posedge mclk_in);
      check(mon[2], 0);
      check(mon[1:0], 2'b10);
      direction_select_in <= 1;
      line_contactor_closed_in <= 1;
      drive <= 0;
      waitfor(4, 1);
      check(mon[1:0], 2'b01);
      speed_actual_in <= 16'h0010;
      waitfor(3, 1);
      check(armature_pulse_inhibit_out, 1);
      repeat (50) @(posedge mclk_in);
      check(mon[3], 1);
      field_brake_in <= 0;
      waitfor(1, 1);
      waitfor(6, 0);
      check(cnt >= 70 && cnt <= 76, 1);
      check(mon[3], 1);
      restart_ack_in <= 1;
      waitfor(3, 0);
      restart_ack_in <= 0;
      check(zero_speed_setpoint_out, 0);
      wb(1, 6'h00, 32'h3);
      reverse(0);
      reverse(1);
      check(mon[1:0], 2'b10);
      check(speed_invert_out, 0);
      tally_and_finish;
   end
   initial begin
      #400000;
      errors++;
      tally_and_finish;
   end
endmodule // tb_top
